// *** src/ipc_pkg.sv ***
package ipc_pkg;
    // Power-control register, special-function address
    localparam logic [7:0] IPC_PWR_CTRL_ADDR = 8'h87;
    // Field positions
    localparam int IPC_BIT_BAUD_DOUBLER = 7;
    localparam int IPC_BIT_USER_FLAG_HI = 3;
    localparam int IPC_BIT_USER_FLAG_LO = 2;
    localparam int IPC_BIT_DEEP_SLEEP = 1;
    localparam int IPC_BIT_LIGHT_SLEEP = 0;
    // Implemented bits; reserved 6..4 read as zero here
    localparam logic [7:0] IPC_PWR_CTRL_MASK = 8'h8f;
    localparam logic [7:0] IPC_PWR_CTRL_RESET = 8'h00;
    // Reset must be seen for 2 machine cycles of 12 osc periods
    localparam int IPC_OSC_PER_MCYCLE = 12;
    localparam int IPC_RESET_MCYCLES = 2;
    localparam int IPC_RESET_OSC_PERIODS = IPC_RESET_MCYCLES
        * IPC_OSC_PER_MCYCLE;
    // Strong pullup time in oscillator periods
    localparam int IPC_PULLUP_OSC_PERIODS = 2;
    localparam int IPC_PORT_W = 8;
    localparam int IPC_RST_CNT_W = 5;
    localparam int IPC_PU_CNT_W = 2;
    typedef enum logic [1:0]
    {
        IPC_RUN = 2'b00,
        IPC_IDLE = 2'b01,
        IPC_PDOWN = 2'b10
    } ipc_mode_t;
endpackage : ipc_pkg

// *** src/ipc_pullup.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipc_pullup
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic osc_en_i,
    input wire logic [7:0] latch_i,
    input wire logic [7:0] addr_hold_i,
    output logic [7:0] strong_o
);
    import ipc_pkg::*;
    typedef struct packed
    {
        logic [7:0] prev_reg;
        logic [7:0][1:0] cnt_reg;
    } ipc_pu_state_t;
    ipc_pu_state_t st_reg;
    ipc_pu_state_t st_next;
    always_comb
    begin
        st_next = st_reg;
        for (int i = 0; i < IPC_PORT_W; i++)
        begin
            if (osc_en_i)
            begin
                // 0-to-1 arms strong pullup for two osc periods
                if (latch_i[i] && !st_reg.prev_reg[i])
                begin
                    st_next.cnt_reg[i] = IPC_PU_CNT_W'(IPC_PULLUP_OSC_PERIODS);
                end
                else if (st_reg.cnt_reg[i] != 2'h0)
                begin
                    st_next.cnt_reg[i] = st_reg.cnt_reg[i] - 2'h1;
                end
                st_next.prev_reg[i] = latch_i[i];
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
    // Address ones keep the strong pullup for the whole access
    always_comb
    begin
        for (int i = 0; i < IPC_PORT_W; i++)
        begin
            strong_o[i] = (st_reg.cnt_reg[i] != 2'h0) || addr_hold_i[i];
        end
    end
endmodule : ipc_pullup
`default_nettype wire

// *** src/ipc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipc_top
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic RST_PIN_I,
    input wire logic SFR_WE_I,
    input wire logic SFR_RE_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic INSN_DONE_I,
    input wire logic IRQ_PEND_I,
    input wire logic EXT_CODE_I,
    input wire logic EXT_ACCESS_I,
    input wire logic CPU_ALE_I,
    input wire logic CPU_FETCH_STROBE_N_I,
    input wire logic [7:0] CPU_P0_I,
    input wire logic CPU_P0_OE_N_I,
    input wire logic [7:0] CPU_ADDR_HI_I,
    input wire logic [7:0] PORT2_LATCH_I,
    input wire logic [7:0] PORT1_LATCH_I,
    input wire logic [7:0] PORT3_LATCH_I,
    output logic OSC_EN_O,
    output logic CPU_CLK_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic SYS_RESET_O,
    output logic BAUD_DOUBLER_O,
    output logic IDLE_O,
    output logic PDOWN_O,
    output logic ALE_O,
    output logic PROGRAM_FETCH_STROBE_N_O,
    output logic [7:0] P0_O,
    output logic P0_OE_N_O,
    output logic [7:0] PORT2_O,
    output logic [7:0] P1_STRONG_O,
    output logic [7:0] PORT2_STRONG_O,
    output logic [7:0] P3_STRONG_O
);
    import ipc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        logic half_reg;
        logic [IPC_RST_CNT_W-1:0] rst_cnt_reg;
        logic sys_rst_reg;
        ipc_mode_t mode_reg;
        logic baud_doubler;
        logic user_flag_hi;
        logic user_flag_lo;
        logic deep_sleep_bit;
        logic light_sleep_bit;
        logic [7:0] rdata_reg;
        logic [7:0] port2_hold_reg;
    } ipc_state_t;
    ipc_state_t st_reg;
    ipc_state_t st_next;
    logic osc_run;
    logic phase_en;
    logic pwr_sel;
    logic [7:0] port2_addr_pu;
    // Oscillator runs unless power-down; reset restarts it
    assign osc_run = (st_reg.mode_reg != IPC_PDOWN) || RST_PIN_I;
    // Half-rate enable: internal phase ignores input duty cycle
    assign phase_en = osc_run && st_reg.half_reg;
    assign pwr_sel = (SFR_ADDR_I == IPC_PWR_CTRL_ADDR);
    always_comb
    begin
        st_next = st_reg;
        if (osc_run)
        begin
            st_next.half_reg = ~st_reg.half_reg;
        end
        // Pin reset filtered over 24 oscillator periods
        if (!RST_PIN_I)
        begin
            st_next.rst_cnt_reg = '0;
            st_next.sys_rst_reg = 1'b0;
        end
        else if (osc_run)
        begin
            if (st_reg.rst_cnt_reg ==
                IPC_RST_CNT_W'(IPC_RESET_OSC_PERIODS - 1))
            begin
                st_next.sys_rst_reg = 1'b1;
            end
            else
            begin
                st_next.rst_cnt_reg = st_reg.rst_cnt_reg + 5'h01;
            end
        end
        if (st_reg.sys_rst_reg)
        begin
            // Any mode, including power-down, ends here
            st_next.mode_reg = IPC_RUN;
            st_next.baud_doubler = 1'b0;
            st_next.user_flag_hi = 1'b0;
            st_next.user_flag_lo = 1'b0;
            st_next.deep_sleep_bit = 1'b0;
            st_next.light_sleep_bit = 1'b0;
        end
        else
        begin
            // Byte write only; bits 6..4 are dropped
            if (SFR_WE_I && pwr_sel && st_reg.mode_reg == IPC_RUN)
            begin
                st_next.baud_doubler = SFR_WDATA_I[IPC_BIT_BAUD_DOUBLER];
                st_next.user_flag_hi = SFR_WDATA_I[IPC_BIT_USER_FLAG_HI];
                st_next.user_flag_lo = SFR_WDATA_I[IPC_BIT_USER_FLAG_LO];
                st_next.deep_sleep_bit = SFR_WDATA_I[IPC_BIT_DEEP_SLEEP];
                st_next.light_sleep_bit = SFR_WDATA_I[IPC_BIT_LIGHT_SLEEP];
            end
            case (st_reg.mode_reg)
                IPC_RUN:
                begin
                    // Entry waits for the requesting instruction to end
                    if (INSN_DONE_I && st_reg.deep_sleep_bit)
                    begin
                        st_next.mode_reg = IPC_PDOWN;
                        st_next.port2_hold_reg = PORT2_LATCH_I;
                    end
                    else if (INSN_DONE_I && st_reg.light_sleep_bit)
                    begin
                        st_next.mode_reg = IPC_IDLE;
                    end
                end
                IPC_IDLE:
                begin
                    if (IRQ_PEND_I)
                    begin
                        st_next.light_sleep_bit = 1'b0;
                        st_next.mode_reg = IPC_RUN;
                    end
                end
                IPC_PDOWN:
                begin
                    // Interrupts ignored: clocks are stopped
                    st_next.mode_reg = IPC_PDOWN;
                end
                default:
                begin
                    st_next.mode_reg = IPC_RUN;
                end
            endcase
        end
        st_next.rdata_reg = 8'h00;
        if (SFR_RE_I && pwr_sel)
        begin
            st_next.rdata_reg = {st_reg.baud_doubler, 3'h0,
                st_reg.user_flag_hi, st_reg.user_flag_lo,
                st_reg.deep_sleep_bit, st_reg.light_sleep_bit};
        end
    end
    always_ff @(posedge CLK_I or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign OSC_EN_O = osc_run;
    // CPU stops in idle, peripherals keep their enable
    assign CPU_CLK_EN_O = phase_en && st_reg.mode_reg == IPC_RUN;
    assign PERIPH_CLK_EN_O = phase_en;
    assign SYS_RESET_O = st_reg.sys_rst_reg;
    assign BAUD_DOUBLER_O = st_reg.baud_doubler;
    assign IDLE_O = st_reg.mode_reg == IPC_IDLE;
    assign PDOWN_O = st_reg.mode_reg == IPC_PDOWN;
    assign SFR_RDATA_O = st_reg.rdata_reg;
    // Pin state per mode
    always_comb
    begin
        ALE_O = CPU_ALE_I;
        PROGRAM_FETCH_STROBE_N_O = CPU_FETCH_STROBE_N_I;
        P0_O = CPU_P0_I;
        P0_OE_N_O = CPU_P0_OE_N_I;
        PORT2_O = CPU_ADDR_HI_I;
        case (st_reg.mode_reg)
            IPC_IDLE:
            begin
                ALE_O = 1'b1;
                PROGRAM_FETCH_STROBE_N_O = 1'b1;
                P0_OE_N_O = EXT_CODE_I ? 1'b1 : CPU_P0_OE_N_I;
            end
            IPC_PDOWN:
            begin
                ALE_O = 1'b0;
                PROGRAM_FETCH_STROBE_N_O = 1'b0;
                P0_OE_N_O = EXT_CODE_I ? 1'b1 : CPU_P0_OE_N_I;
                PORT2_O = st_reg.port2_hold_reg;
            end
            default:
            begin
                ALE_O = CPU_ALE_I;
            end
        endcase
    end
    // Address ones held strong only while bus access runs
    assign port2_addr_pu = (EXT_ACCESS_I && st_reg.mode_reg != IPC_PDOWN)
        ? CPU_ADDR_HI_I : 8'h00;
    ////////////////////////////////////////////////////////////////////////
    ipc_pullup u_pu1
    (
        .clk_i(CLK_I),
        .rst_n_i(rst_n_reg),
        .osc_en_i(osc_run),
        .latch_i(PORT1_LATCH_I),
        .addr_hold_i(8'h00),
        .strong_o(P1_STRONG_O)
    );
    ipc_pullup u_pu2
    (
        .clk_i(CLK_I),
        .rst_n_i(rst_n_reg),
        .osc_en_i(osc_run),
        .latch_i(PORT2_O),
        .addr_hold_i(port2_addr_pu),
        .strong_o(PORT2_STRONG_O)
    );
    ipc_pullup u_pu3
    (
        .clk_i(CLK_I),
        .rst_n_i(rst_n_reg),
        .osc_en_i(osc_run),
        .latch_i(PORT3_LATCH_I),
        .addr_hold_i(8'h00),
        .strong_o(P3_STRONG_O)
    );
endmodule : ipc_top
`default_nettype wire

// *** test/ipc_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipc_sva
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic RST_PIN_I,
    input wire logic IRQ_PEND_I,
    input wire logic EXT_CODE_I,
    input wire logic [7:0] PORT1_LATCH_I,
    input wire logic OSC_EN_O,
    input wire logic CPU_CLK_EN_O,
    input wire logic PERIPH_CLK_EN_O,
    input wire logic SYS_RESET_O,
    input wire logic IDLE_O,
    input wire logic PDOWN_O,
    input wire logic ALE_O,
    input wire logic PROGRAM_FETCH_STROBE_N_O,
    input wire logic P0_OE_N_O,
    input wire logic [7:0] P1_STRONG_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    ////////////////////////////////////////////////////////////////////////
    a_div_two: assert property (
        !PDOWN_O && !$past(PDOWN_O) && !SYS_RESET_O && !$past(SYS_RESET_O)
        && $past(ARST_N_I, 3) |-> PERIPH_CLK_EN_O != $past(PERIPH_CLK_EN_O))
        else $error("peripheral enable not every second edge");
    a_idle_cpu_gate: assert property (IDLE_O |-> !CPU_CLK_EN_O)
        else $error("cpu clock running in light sleep");
    a_deep_osc_off: assert property (
        PDOWN_O && !RST_PIN_I |-> !OSC_EN_O && !PERIPH_CLK_EN_O)
        else $error("clock running in deep sleep");
    a_idle_pins: assert property (
        IDLE_O |-> ALE_O && PROGRAM_FETCH_STROBE_N_O
        && (!EXT_CODE_I || P0_OE_N_O))
        else $error("pin state wrong in light sleep");
    a_deep_pins: assert property (
        PDOWN_O |-> !ALE_O && !PROGRAM_FETCH_STROBE_N_O
        && (!EXT_CODE_I || P0_OE_N_O))
        else $error("pin state wrong in deep sleep");
    a_irq_wake: assert property (
        IDLE_O && IRQ_PEND_I && !RST_PIN_I |=> !IDLE_O && !PDOWN_O)
        else $error("interrupt did not end light sleep");
    a_deep_hold: assert property (
        PDOWN_O && !RST_PIN_I && !SYS_RESET_O |=> PDOWN_O)
        else $error("deep sleep left without reset");
    a_rst_len: assert property (
        $rose(SYS_RESET_O) |-> $past(RST_PIN_I) && $past(RST_PIN_I, 24))
        else $error("system reset after too short a pin pulse");
    a_rst_drop: assert property (
        SYS_RESET_O && !RST_PIN_I |=> !SYS_RESET_O)
        else $error("system reset outlived the pin");
    a_pullup_pulse: assert property (
        $rose(PORT1_LATCH_I[0]) && !PDOWN_O |-> ##1 P1_STRONG_O[0]
        ##1 P1_STRONG_O[0] ##1 !P1_STRONG_O[0])
        else $error("strong pullup pulse length wrong");
    c_idle_exit: cover property (IDLE_O ##1 !IDLE_O);
    c_deep_entry: cover property ($rose(PDOWN_O));
    c_sys_reset: cover property ($rose(SYS_RESET_O));
endmodule : ipc_sva
bind ipc_top ipc_sva u_sva
(
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .RST_PIN_I(RST_PIN_I),
    .IRQ_PEND_I(IRQ_PEND_I), .EXT_CODE_I(EXT_CODE_I),
    .PORT1_LATCH_I(PORT1_LATCH_I), .OSC_EN_O(OSC_EN_O),
    .CPU_CLK_EN_O(CPU_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
    .SYS_RESET_O(SYS_RESET_O), .IDLE_O(IDLE_O), .PDOWN_O(PDOWN_O),
    .ALE_O(ALE_O), .PROGRAM_FETCH_STROBE_N_O(PROGRAM_FETCH_STROBE_N_O),
    .P0_OE_N_O(P0_OE_N_O), .P1_STRONG_O(P1_STRONG_O)
);
`default_nettype wire

// *** test/ipc_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model
(
    input wire logic clk_i,
    input wire logic cpu_clk_en_i,
    output logic ale_o,
    output logic fetch_n_o,
    output logic [7:0] p0_o,
    output logic p0_oe_n_o,
    output logic [7:0] addr_hi_o,
    output logic ext_access_o
);
    // Fetch counter moves only on cpu enables, so gating shows as a freeze
    logic [7:0] pc_reg = 8'h00;
    always @(posedge clk_i)
    begin
        if (cpu_clk_en_i)
        begin
            pc_reg <= pc_reg + 8'h01;
        end
    end
    assign ale_o = pc_reg[1];
    assign fetch_n_o = pc_reg[0];
    assign p0_o = ~pc_reg;
    assign p0_oe_n_o = pc_reg[2];
    assign addr_hi_o = {pc_reg[3:0], ~pc_reg[7:4]};
    assign ext_access_o = pc_reg[3];
endmodule : ipc_cpu_model
`default_nettype wire

// *** test/tb_ipc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ipc_top;
    import ipc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic rst_pin = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic insn_done = 1'b0;
    logic irq = 1'b0;
    logic ext_code = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] lat1 = 8'h00;
    logic [7:0] lat2 = 8'h00;
    logic [7:0] lat3 = 8'h00;
    logic [7:0] rdata, p0, port2, cp0, cp2, s1, s2, s3;
    logic osc_en, sys_rst, baud, idle, pdown, ale, fetch_n, p0_oe_n;
    logic c_ale, c_fetch_n, c_oe_n, ext_acc, cpu_en, periph;
    int n_errors = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    ipc_cpu_model u_cpu (.clk_i(clk), .cpu_clk_en_i(cpu_en), .ale_o(c_ale),
        .fetch_n_o(c_fetch_n), .p0_o(cp0), .p0_oe_n_o(c_oe_n),
        .addr_hi_o(cp2), .ext_access_o(ext_acc));
    ipc_top DUT (.CLK_I(clk), .ARST_N_I(arst_n), .RST_PIN_I(rst_pin),
        .SFR_WE_I(we), .SFR_RE_I(re), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata),
        .SFR_RDATA_O(rdata), .INSN_DONE_I(insn_done), .IRQ_PEND_I(irq),
        .EXT_CODE_I(ext_code), .EXT_ACCESS_I(ext_acc), .CPU_ALE_I(c_ale),
        .CPU_FETCH_STROBE_N_I(c_fetch_n), .CPU_P0_I(cp0),
        .CPU_P0_OE_N_I(c_oe_n), .CPU_ADDR_HI_I(cp2), .PORT2_LATCH_I(lat2),
        .PORT1_LATCH_I(lat1), .PORT3_LATCH_I(lat3), .OSC_EN_O(osc_en),
        .CPU_CLK_EN_O(cpu_en), .PERIPH_CLK_EN_O(periph),
        .SYS_RESET_O(sys_rst), .BAUD_DOUBLER_O(baud),
        .IDLE_O(idle), .PDOWN_O(pdown), .ALE_O(ale),
        .PROGRAM_FETCH_STROBE_N_O(fetch_n), .P0_O(p0), .P0_OE_N_O(p0_oe_n),
        .PORT2_O(port2), .P1_STRONG_O(s1), .PORT2_STRONG_O(s2),
        .P3_STRONG_O(s3));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Ends on the edge: drives land by NBA, reads see the settled cycle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        // Data stands one cycle; taken at the edge that closes it
        @(posedge clk);
        d = rdata;
    endtask : sfr_rd
    task automatic done();
        @(posedge clk);
        insn_done <= 1'b1;
        @(posedge clk);
        insn_done <= 1'b0;
    endtask : done
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        logic [7:0] d;
        logic pe;
        wt(2);
        arst_n <= 1'b1;
        wt(3);
        sfr_rd(IPC_PWR_CTRL_ADDR, d);
        check(d, 8'h00);
        sfr_wr(8'h86, 8'hff);
        sfr_rd(8'h86, d);
        check(d, 8'h00);
        sfr_rd(IPC_PWR_CTRL_ADDR, d);
        check(d, 8'h00);
        sfr_wr(IPC_PWR_CTRL_ADDR, 8'hfc);
        sfr_rd(IPC_PWR_CTRL_ADDR, d);
        check(d, 8'h8c);
        check({6'h00, baud, idle | pdown}, 8'h02);
        pe = cpu_en;
        wt(1);
        check({7'h00, cpu_en ^ pe}, 8'h01);
        sfr_wr(IPC_PWR_CTRL_ADDR, 8'h05);
        done();
        wt(2);
        check({6'h00, idle, pdown}, 8'h02);
        check({7'h00, baud}, 8'h00);
        check({5'h00, ale, fetch_n, cpu_en}, 8'h06);
        check(p0, cp0);
        pe = periph;
        wt(1);
        check({7'h00, periph ^ pe}, 8'h01);
        // Refused while asleep, so the later read shows only bit 0 cleared by the wake
        sfr_wr(IPC_PWR_CTRL_ADDR, 8'h80);
        wt(8);
        check(s2, ext_acc ? cp2 : 8'h00);
        irq <= 1'b1;
        wt(2);
        irq <= 1'b0;
        check({6'h00, idle, pdown}, 8'h00);
        sfr_rd(IPC_PWR_CTRL_ADDR, d);
        check(d, 8'h04);
        lat1 <= 8'h01;
        lat3 <= 8'h81;
        wt(2);
        check(s3, 8'h81);
        check(s1, 8'h01);
        wt(1);
        check(s3, 8'h81);
        wt(1);
        check(s3, 8'h00);
        ext_code <= 1'b1;
        lat2 <= 8'ha5;
        sfr_wr(IPC_PWR_CTRL_ADDR, 8'h03);
        done();
        irq <= 1'b1;
        wt(2);
        check({6'h00, idle, pdown}, 8'h01);
        check({6'h00, osc_en, periph}, 8'h00);
        check(port2, 8'ha5);
        check({5'h00, ale, fetch_n, p0_oe_n}, 8'h01);
        wt(8);
        check({6'h00, idle, pdown}, 8'h01);
        irq <= 1'b0;
        rst_pin <= 1'b1;
        wt(2);
        check({7'h00, osc_en}, 8'h01);
        wt(8);
        rst_pin <= 1'b0;
        wt(2);
        check({6'h00, idle, pdown}, 8'h01);
        // Held well past the count to let the oscillator settle
        rst_pin <= 1'b1;
        wt(24);
        check({7'h00, sys_rst}, 8'h00);
        wt(1);
        check({7'h00, sys_rst}, 8'h01);
        wt(15);
        check({6'h00, idle, pdown}, 8'h00);
        rst_pin <= 1'b0;
        wt(2);
        check({7'h00, sys_rst}, 8'h00);
        sfr_rd(IPC_PWR_CTRL_ADDR, d);
        check(d, 8'h00);
        sfr_wr(IPC_PWR_CTRL_ADDR, 8'h01);
        done();
        wt(2);
        check({6'h00, idle, pdown}, 8'h02);
        check({7'h00, p0_oe_n}, 8'h01);
        check(port2, cp2);
        rst_pin <= 1'b1;
        wt(26);
        check({7'h00, sys_rst}, 8'h01);
        check({6'h00, idle, pdown}, 8'h00);
        rst_pin <= 1'b0;
        wt(2);
        end_of_test();
    end
endmodule : tb_ipc_top
`default_nettype wire
